// ===== common/qec_pkg.sv
// Package for the quadrature encoder counter: widths, filter lengths, modes.
// Assumes a single sample clock of 50 MHz feeding every consumer.
package qec_pkg;
  localparam int QEC_CLK_HZ = 50_000_000;
  localparam int QEC_CNT_W = 32;
  localparam logic [3:0] QEC_FILT_LONG = 4'hF;
  localparam logic [3:0] QEC_FILT_SHORT = 4'h3;
  localparam logic [QEC_CNT_W-1:0] QEC_CNT_RST = 32'h0000_0000;
  localparam logic QEC_MODE_QUAD = 1'b0;
  localparam logic QEC_FILT_DEF = 1'b1;

  typedef struct packed {
    logic counter_mode;
    logic filter_long;
    logic index_rise;
    logic gate_en;
    logic gate_low;
  } qec_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic idx;
    logic gate;
  } qec_pins_t;
endpackage : qec_pkg

// ===== verilog/qec_filter.sv
// Glitch filter for one input bit: three-stage synchroniser and stability counter.
// Assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/1ps
module qec_filter (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic din_i,
  input wire logic [3:0] len_i,
  output logic dout_o
);
  import qec_pkg::*;
  logic s1_reg, s2_reg, s3_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // The output only follows once the settled level differs for len_i clocks in a row.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 4'h0;
      dout_o <= 1'b0;
    end else if (s2_reg != s3_reg || s3_reg == dout_o) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg + 4'h1 >= len_i) begin
      cnt_reg <= 4'h0;
      dout_o <= s3_reg;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : qec_filter

// ===== verilog/qec_counter.sv
// Quadrature encoder counter top: filtered inputs, decode, count and raw count.
// Assumes configuration and host controls are synchronous to ref_clk_i.
//
// Functional notes
// - The instance takes A, B and index, plus a qualifying gate input when HAS_GATE is set.
// - A signed 32-bit count holds decoded edges since the last host clear or index capture.
// - A signed 32-bit raw count holds all decoded edges since reset and is never cleared.
// - While the host clear is high the count is held at zero and the clear is left alone.
// - An armed capture zeroes the count on the next qualified index edge and drops the arm.
// - With counter mode low, A and B decode as quadrature with four counts per cycle.
// - With counter mode high, each rising edge of A counts in the direction given by B.
// - With the long filter selected an A, B or index change is taken after 15 stable clocks.
// - With the short filter selected an input change is taken after 3 stable clocks.
// - Filter lengths count cycles of the 50 MHz sample clock.
// - The index edge used is rising when index-rise is set, falling otherwise.
// - With gating on, index edges count only while the gate input is at its active level.
// - The gate active level is low when gate-low is set and high otherwise.
`timescale 1ns/1ps
module qec_counter #(
  parameter bit HAS_GATE = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire qec_pkg::qec_pins_t pins_i,
  input wire qec_pkg::qec_cfg_t cfg_i,
  input wire logic cfg_load_i,
  input wire logic clear_i,
  input wire logic arm_set_i,
  output logic arm_o,
  output logic capture_o,
  output logic signed [qec_pkg::QEC_CNT_W-1:0] count_o,
  output logic signed [qec_pkg::QEC_CNT_W-1:0] raw_o
);
  import qec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  qec_cfg_t cfg_reg;
  logic [3:0] flen;
  logic fa, fb, fi, fg;
  logic pa_reg, pb_reg, pi_reg;
  logic step, up, idx_edge, gate_ok, capture;

  // Configuration is latched so reset can restore the defaults independently of the ports.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= '{counter_mode: QEC_MODE_QUAD, filter_long: QEC_FILT_DEF,
                   index_rise: 1'b1, gate_en: 1'b0, gate_low: 1'b0};
    end else if (cfg_load_i) begin
      cfg_reg <= cfg_i;
    end
  end

  assign flen = cfg_reg.filter_long ? QEC_FILT_LONG : QEC_FILT_SHORT;

  ////////////////////////////////////////////////////////////////////////////
  qec_filter u_fa (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .din_i(pins_i.a), .len_i(flen),
                   .dout_o(fa));
  qec_filter u_fb (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .din_i(pins_i.b), .len_i(flen),
                   .dout_o(fb));
  qec_filter u_fi (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .din_i(pins_i.idx), .len_i(flen),
                   .dout_o(fi));

  // The gate input is not a counting line, so it only gets the short filter.
  generate
    if (HAS_GATE) begin : g_gate
      qec_filter u_fg (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .din_i(pins_i.gate),
                       .len_i(QEC_FILT_SHORT), .dout_o(fg));
    end else begin : g_nogate
      assign fg = 1'b0;
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pa_reg <= 1'b0;
      pb_reg <= 1'b0;
      pi_reg <= 1'b0;
    end else begin
      pa_reg <= fa;
      pb_reg <= fb;
      pi_reg <= fi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In quadrature mode only single-bit Gray steps count; a double change means lost samples, so it is dropped.
  always_comb begin
    step = 1'b0;
    up = 1'b0;
    if (cfg_reg.counter_mode) begin
      step = fa && !pa_reg;
      up = fb;
    end else if ((fa ^ pa_reg) ^ (fb ^ pb_reg)) begin
      step = 1'b1;
      up = (fa ^ pb_reg);
    end
  end

  assign idx_edge = cfg_reg.index_rise ? (fi && !pi_reg) : (!fi && pi_reg);
  assign gate_ok = !HAS_GATE || !cfg_reg.gate_en || (fg ^ cfg_reg.gate_low);
  assign capture = arm_o && idx_edge && gate_ok;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_o <= QEC_CNT_RST;
    end else if (step) begin
      raw_o <= up ? raw_o + 32'sh1 : raw_o - 32'sh1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_o <= QEC_CNT_RST;
    end else if (clear_i || capture) begin
      count_o <= QEC_CNT_RST;
    end else if (step) begin
      count_o <= up ? count_o + 32'sh1 : count_o - 32'sh1;
    end
  end

  // A set request in the capture cycle loses: the host re-arms after seeing the flag drop.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arm_o <= 1'b0;
      capture_o <= 1'b0;
    end else begin
      capture_o <= capture;
      if (capture) begin
        arm_o <= 1'b0;
      end else if (arm_set_i) begin
        arm_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_clear_holds: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clear_i |=> count_o == 32'sh0) else $error("count not zero under clear");
  chk_capture_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    capture |=> (count_o == 32'sh0 && !arm_o && capture_o)) else $error("capture failed");
  chk_raw_step: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    step && up |=> raw_o == $past(raw_o) + 32'sh1) else $error("raw up miscount");
  chk_raw_down: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    step && !up |=> raw_o == $past(raw_o) - 32'sh1) else $error("raw down miscount");
  chk_raw_idle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !step |=> $stable(raw_o)) else $error("raw moved without step");
  chk_illegal_skip: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!cfg_reg.counter_mode && fa != pa_reg && fb != pb_reg) |-> !step)
    else $error("illegal step counted");
  chk_updown_rise: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (cfg_reg.counter_mode && !fa) |-> !step) else $error("count without A rise");
  chk_gate_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (HAS_GATE && cfg_reg.gate_en && (fg == cfg_reg.gate_low)) |-> !capture)
    else $error("gated index captured");
  chk_quad_dir: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!cfg_reg.counter_mode && !pa_reg && !pb_reg && fa && !fb) |-> (step && up))
    else $error("A leading B not counted up");
endmodule : qec_counter

// ===== tb/qec_enc_model.sv
// Encoder partner model: drives the A, B, index and gate lines.
// Assumes the bench calls its tasks; lines move on the falling edge.
`timescale 1ns/1ps
module qec_enc_model (
  input wire logic ref_clk_i,
  output qec_pkg::qec_pins_t pins_o
);
  import qec_pkg::*;
  initial pins_o = '0;
  // Bit 3 is A, 2 is B, 1 is index, 0 is gate; the new level stays hold cycles.
  task automatic flip(input int bitn, input int hold);
    @(negedge ref_clk_i);
    pins_o[bitn] = ~pins_o[bitn];
    repeat (hold) @(negedge ref_clk_i);
  endtask : flip
  // Forward motion has A leading B, so only one line moves per step.
  task automatic step(input logic up, input int hold);
    if (up ^ pins_o.a ^ pins_o.b) flip(3, hold);
    else flip(2, hold);
  endtask : step
endmodule : qec_enc_model

// ===== tb/testbench.sv
// Self-checking bench for the quadrature encoder counter.
// Assumes the partner model in qec_enc_model and a 50 MHz sample clock.
`timescale 1ns/1ps
module testbench;
  import qec_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  qec_pins_t pins;
  qec_cfg_t cfg = 5'h0;
  logic cfg_load = 1'b0;
  logic clear = 1'b0;
  logic arm_set = 1'b0;
  logic arm;
  logic capture;
  logic signed [QEC_CNT_W-1:0] count;
  logic signed [QEC_CNT_W-1:0] raw;
  logic [31:0] n_caps = 32'h0;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  qec_counter #(.HAS_GATE(1'b1)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .pins_i(pins), .cfg_i(cfg), .cfg_load_i(cfg_load), .clear_i(clear),
    .arm_set_i(arm_set), .arm_o(arm), .capture_o(capture), .count_o(count), .raw_o(raw));
  qec_enc_model u_enc (.ref_clk_i(ref_clk_i), .pins_o(pins));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // The whole run needs about 550 cycles; the ceiling of 3000 leaves ample margin.
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (capture === 1'b1) n_caps <= n_caps + 32'h1;
    if (cycles == 3000) begin
      failures = failures + 1;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic chk(input logic [31:0] c, input logic [31:0] r);
    cmp_val(count, c);
    cmp_val(raw, r);
  endtask : chk
  task automatic load(input qec_cfg_t c);
    @(negedge ref_clk_i);
    cfg = c;
    cfg_load = 1'b1;
    @(negedge ref_clk_i);
    cfg_load = 1'b0;
  endtask : load
  task automatic arm_it();
    @(negedge ref_clk_i);
    arm_set = 1'b1;
    @(negedge ref_clk_i);
    arm_set = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : arm_it
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    chk(32'h0, 32'h0);
    cmp_bit(arm, 1'b0);
    repeat (4) u_enc.step(1'b1, 25);
    chk(32'h4, 32'h4);
    u_enc.step(1'b0, 25);
    chk(32'h3, 32'h3);
    u_enc.flip(3, 8);
    u_enc.flip(3, 25);
    chk(32'h3, 32'h3);
    $display("test count_filter done");
    clear = 1'b1;
    u_enc.step(1'b1, 25);
    chk(32'h0, 32'h4);
    clear = 1'b0;
    arm_it();
    cmp_bit(arm, 1'b1);
    u_enc.step(1'b1, 25);
    chk(32'h1, 32'h5);
    u_enc.flip(1, 25);
    chk(32'h0, 32'h5);
    cmp_bit(arm, 1'b0);
    cmp_val(n_caps, 32'h1);
    u_enc.flip(1, 25);
    $display("test clear_capture done");
    load(5'h03);
    u_enc.flip(0, 25);
    u_enc.step(1'b1, 10);
    chk(32'h1, 32'h6);
    arm_it();
    u_enc.flip(1, 25);
    u_enc.flip(1, 25);
    cmp_bit(arm, 1'b1);
    u_enc.flip(0, 25);
    u_enc.flip(1, 25);
    u_enc.flip(1, 25);
    chk(32'h0, 32'h6);
    cmp_bit(arm, 1'b0);
    $display("test gated_index done");
    load(5'h14);
    u_enc.flip(3, 10);
    u_enc.flip(3, 10);
    chk(32'h1, 32'h7);
    u_enc.flip(2, 10);
    u_enc.flip(3, 10);
    u_enc.flip(3, 10);
    chk(32'h0, 32'h6);
    $display("test up_down done");
    // Park the lines at 00 so the reset below starts from the idle pattern.
    u_enc.flip(3, 10);
    chk(32'h0, 32'h6);
    rstn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    chk(32'h0, 32'h0);
    cmp_bit(arm, 1'b0);
    // With B low a count mode would step down, so +1 shows quadrature came back.
    u_enc.step(1'b1, 10);
    chk(32'h0, 32'h0);
    repeat (15) @(negedge ref_clk_i);
    chk(32'h1, 32'h1);
    $display("test reset_defaults done");
    complete_run();
  end
endmodule : testbench
